// ===== rtl/wfpx_pkg.sv
// Purpose: Shared constants and types for the waveform fault and pattern
//          extension.
// Assumes: Eight-bit register port, one peripheral clock.
// Notes:   Byte offsets are those of the register map.
package wfpx_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] WFPX_OFS_CTRL = 4'h0;
  localparam logic [3:0] WFPX_OFS_MASK = 4'h2;
  localparam logic [3:0] WFPX_OFS_FCTL = 4'h3;
  localparam logic [3:0] WFPX_OFS_STAT = 4'h4;
  localparam logic [3:0] WFPX_OFS_BOTH = 4'h6;
  localparam logic [3:0] WFPX_OFS_BOTHBUF = 4'h7;
  localparam logic [3:0] WFPX_OFS_LSD = 4'h8;
  localparam logic [3:0] WFPX_OFS_HSD = 4'h9;
  localparam logic [3:0] WFPX_OFS_LSBUF = 4'hA;
  localparam logic [3:0] WFPX_OFS_HSBUF = 4'hB;
  localparam logic [3:0] WFPX_OFS_OVEN = 4'hC;

  // ---------------------------------------------------------------------
  // Field positions and reset value
  // ---------------------------------------------------------------------
  localparam int WFPX_BIT_PATTERN = 5;
  localparam int WFPX_BIT_COMMON = 4;
  localparam int WFPX_BIT_DBGIGN = 4;
  localparam int WFPX_BIT_RESTART = 2;
  localparam int WFPX_BIT_FAULT = 2;
  localparam int WFPX_BIT_HSV = 1;
  localparam int WFPX_BIT_LSV = 0;
  localparam logic [7:0] WFPX_RESET_VAL = 8'h00;
  localparam logic [1:0] WFPX_ACT_NONE = 2'h0;
  localparam logic [1:0] WFPX_ACT_TRISTATE = 2'h3;

  // Worst case from event to action, in peripheral clock cycles.
  localparam int WFPX_FAULT_LATENCY = 2;

  // Timer side inputs that travel together.
  typedef struct packed {
    logic [3:0] wave;
    logic update;
    logic update_lock_flag;
  } wfpx_timer_t;

  // Port side outputs that travel together.
  typedef struct packed {
    logic [7:0] override_en;
    logic [7:0] override_val;
    logic [7:0] dir_clear;
  } wfpx_port_t;

endpackage

// ===== rtl/wfpx_top.sv
// Purpose: Pattern generator, common channel mode, channel enables and
//          event driven fault protection of a timer waveform extension.
// Assumes: Registers reached over a plain strobe port, read data one
//          cycle after the read strobe. Dead-time counters live outside.
// Notes:   All state is one packed struct registered once per cycle.
//
// Overview of operation
// - Pattern bit: pattern, common mode, no dead time
// - Pattern mode: enabled pins carry channel A
// - Pattern buffers load only at UPDATE
// - Eight mask bits, enabled events ORed together
// - Fault sets flag and timer error flag
// - Fault action within two clock cycles
// - Fault path is pure hardware on clock
// - Latched: wait clear and no fault, UPDATE
// - Cycle mode: resume at UPDATE after fault
// - Restart bit zero latched, one cycle mode
// - Leaving fault restores enabled channel directions
// - Fault keeps overrides, blocks their writes
// - Lock blocks control, override, mask writes
// - Debug break is fault unless ignore bit or action 00
// - After break resume like the restart mode
// - Common bit feeds channel A everywhere
// - Channel enables make dead-time replace waveform
// - Action 00 off, 11 tristate, others reserved
// - Fault flag set by event, write one clears
// - Buffer valid bits gate UPDATE copy, lock blocks
// - Override bits act on output value only
`timescale 1ns/1ps
module wfpx_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ext_lock,
  input wire logic [7:0] event_lines,
  input wire logic debug_halt_request,
  input wire wfpx_pkg::wfpx_timer_t timer_in,
  output logic [3:0] channel_dead_time_enables,
  output logic [3:0] dead_time_wave,
  output logic [7:0] low_side_delay,
  output logic [7:0] high_side_delay,
  output wfpx_pkg::wfpx_port_t port_out,
  output logic timer_error_set,
  output logic fault_active
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic pattern_mode_bit;
    logic common_channel_bit;
    logic [3:0] chan_en;
    logic [7:0] fault_source_mask;
    logic debug_break_ignore_bit;
    logic restart_mode_bit;
    logic [1:0] fault_action_field;
    logic fault_flag;
    logic high_side_buffer_valid;
    logic low_side_buffer_valid;
    logic [7:0] lsd;
    logic [7:0] hsd;
    logic [7:0] lsbuf;
    logic [7:0] hsbuf;
    logic [7:0] output_override_enables;
    logic in_fault;
    logic err_pulse;
    logic [3:0] wave;
    logic [7:0] ov_en;
    logic [7:0] ov_val;
    logic [7:0] dir_clr;
    logic [7:0] rdata;
    logic [3:0] cde;
  } wfpx_state_t;

  wfpx_state_t s_q;
  wfpx_state_t s_d;

  logic fault_now;
  logic protect_on;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_fctl;
  logic wr_stat;
  logic wr_oven;
  logic [7:0] ch_pins;
  logic leave;

  // ---------------------------------------------------------------------
  // Fault source and write decode
  // ---------------------------------------------------------------------
  // Events come from same-clock logic, so no synchroniser is placed; that
  // keeps the event to action path inside two cycles.
  always_comb begin
    protect_on = (s_q.fault_action_field != wfpx_pkg::WFPX_ACT_NONE);
    fault_now = |(event_lines & s_q.fault_source_mask);
    if (protect_on && !s_q.debug_break_ignore_bit && debug_halt_request) begin
      fault_now = 1'b1;
    end
    // Lock freezes the control, mask and override registers.
    wr_ctrl = reg_wr && !ext_lock && reg_addr == wfpx_pkg::WFPX_OFS_CTRL;
    wr_mask = reg_wr && !ext_lock && reg_addr == wfpx_pkg::WFPX_OFS_MASK;
    wr_oven = reg_wr && !ext_lock && !s_q.fault_flag
              && reg_addr == wfpx_pkg::WFPX_OFS_OVEN;
    wr_fctl = reg_wr && reg_addr == wfpx_pkg::WFPX_OFS_FCTL;
    wr_stat = reg_wr && reg_addr == wfpx_pkg::WFPX_OFS_STAT;
    // Each channel owns a pin pair.
    for (int i = 0; i < 4; i++) begin
      ch_pins[2*i] = s_q.chan_en[i];
      ch_pins[2*i+1] = s_q.chan_en[i];
    end
    // Latched mode also waits for software to clear the flag.
    leave = s_q.in_fault && !fault_now && timer_in.update
            && (s_q.restart_mode_bit || !s_q.fault_flag);
  end

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.err_pulse = 1'b0;
    if (wr_ctrl) begin
      s_d.pattern_mode_bit = reg_wdata[wfpx_pkg::WFPX_BIT_PATTERN];
      s_d.common_channel_bit = reg_wdata[wfpx_pkg::WFPX_BIT_COMMON];
      s_d.chan_en = reg_wdata[3:0];
    end
    // Pattern mode bypasses dead-time insertion, so the enables read zero.
    s_d.cde = s_d.pattern_mode_bit ? 4'h0 : s_d.chan_en;
    if (wr_mask) begin
      s_d.fault_source_mask = reg_wdata;
    end
    if (wr_fctl) begin
      s_d.debug_break_ignore_bit = reg_wdata[wfpx_pkg::WFPX_BIT_DBGIGN];
      s_d.restart_mode_bit = reg_wdata[wfpx_pkg::WFPX_BIT_RESTART];
      s_d.fault_action_field = reg_wdata[1:0];
    end
    if (wr_oven) begin
      s_d.output_override_enables = reg_wdata;
    end
    // Dead-time and pattern storage, live and buffered.
    if (reg_wr) begin
      case (reg_addr)
        wfpx_pkg::WFPX_OFS_BOTH: begin
          s_d.lsd = reg_wdata;
          s_d.hsd = reg_wdata;
        end
        wfpx_pkg::WFPX_OFS_BOTHBUF: begin
          s_d.lsbuf = reg_wdata;
          s_d.hsbuf = reg_wdata;
          s_d.low_side_buffer_valid = 1'b1;
          s_d.high_side_buffer_valid = 1'b1;
        end
        wfpx_pkg::WFPX_OFS_LSD: s_d.lsd = reg_wdata;
        wfpx_pkg::WFPX_OFS_HSD: s_d.hsd = reg_wdata;
        wfpx_pkg::WFPX_OFS_LSBUF: begin
          s_d.lsbuf = reg_wdata;
          s_d.low_side_buffer_valid = 1'b1;
        end
        wfpx_pkg::WFPX_OFS_HSBUF: begin
          s_d.hsbuf = reg_wdata;
          s_d.high_side_buffer_valid = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Software may also clear the valid bits by writing one.
    if (wr_stat && reg_wdata[wfpx_pkg::WFPX_BIT_LSV]) begin
      s_d.low_side_buffer_valid = 1'b0;
    end
    if (wr_stat && reg_wdata[wfpx_pkg::WFPX_BIT_HSV]) begin
      s_d.high_side_buffer_valid = 1'b0;
    end
    // Buffered copy only at UPDATE and only when the timer is not locked.
    if (timer_in.update && !timer_in.update_lock_flag) begin
      if (s_q.low_side_buffer_valid) begin
        s_d.lsd = s_q.lsbuf;
        s_d.low_side_buffer_valid = 1'b0;
      end
      if (s_q.high_side_buffer_valid) begin
        s_d.hsd = s_q.hsbuf;
        s_d.high_side_buffer_valid = 1'b0;
      end
    end
    // Write one clears the flag, but a new fault in the same cycle wins.
    if (wr_stat && reg_wdata[wfpx_pkg::WFPX_BIT_FAULT]) begin
      s_d.fault_flag = 1'b0;
    end
    if (fault_now) begin
      s_d.fault_flag = 1'b1;
      s_d.err_pulse = 1'b1;
      s_d.in_fault = 1'b1;
    end else if (leave) begin
      s_d.in_fault = 1'b0;
    end
    // Waveform routing to the dead-time units.
    if (s_q.common_channel_bit || s_q.pattern_mode_bit) begin
      s_d.wave = {4{timer_in.wave[0]}};
    end else begin
      s_d.wave = timer_in.wave;
    end
    // Port overrides act on output values, never on directions.
    if (s_q.pattern_mode_bit) begin
      s_d.ov_en = s_q.lsd;
      for (int i = 0; i < 8; i++) begin
        s_d.ov_val[i] = s_q.lsd[i] ? timer_in.wave[0] : s_q.hsd[i];
      end
    end else begin
      s_d.ov_en = s_q.output_override_enables & ch_pins;
      s_d.ov_val = 8'h00;
    end
    // Tristate action; released again when the fault state ends.
    if ((fault_now || (s_q.in_fault && !leave))
        && s_q.fault_action_field == wfpx_pkg::WFPX_ACT_TRISTATE) begin
      s_d.dir_clr = ch_pins;
    end else begin
      s_d.dir_clr = 8'h00;
    end
    // Read data stands for the cycle after the strobe only.
    s_d.rdata = wfpx_pkg::WFPX_RESET_VAL;
    if (reg_rd) begin
      case (reg_addr)
        wfpx_pkg::WFPX_OFS_CTRL:
          s_d.rdata = {2'h0, s_q.pattern_mode_bit, s_q.common_channel_bit,
                       s_q.chan_en};
        wfpx_pkg::WFPX_OFS_MASK: s_d.rdata = s_q.fault_source_mask;
        wfpx_pkg::WFPX_OFS_FCTL:
          s_d.rdata = {3'h0, s_q.debug_break_ignore_bit, 1'b0,
                       s_q.restart_mode_bit, s_q.fault_action_field};
        wfpx_pkg::WFPX_OFS_STAT:
          s_d.rdata = {5'h00, s_q.fault_flag, s_q.high_side_buffer_valid,
                       s_q.low_side_buffer_valid};
        wfpx_pkg::WFPX_OFS_BOTH: s_d.rdata = s_q.lsd;
        wfpx_pkg::WFPX_OFS_BOTHBUF: s_d.rdata = s_q.lsbuf;
        wfpx_pkg::WFPX_OFS_LSD: s_d.rdata = s_q.lsd;
        wfpx_pkg::WFPX_OFS_HSD: s_d.rdata = s_q.hsd;
        wfpx_pkg::WFPX_OFS_LSBUF: s_d.rdata = s_q.lsbuf;
        wfpx_pkg::WFPX_OFS_HSBUF: s_d.rdata = s_q.hsbuf;
        wfpx_pkg::WFPX_OFS_OVEN: s_d.rdata = s_q.output_override_enables;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a flip-flop of the state.
  assign reg_rdata = s_q.rdata;
  // Enables are registered with the pattern bypass already applied.
  assign channel_dead_time_enables = s_q.cde;
  assign dead_time_wave = s_q.wave;
  assign low_side_delay = s_q.lsd;
  assign high_side_delay = s_q.hsd;
  assign port_out.override_en = s_q.ov_en;
  assign port_out.override_val = s_q.ov_val;
  assign port_out.dir_clear = s_q.dir_clr;
  assign timer_error_set = s_q.err_pulse;
  assign fault_active = s_q.in_fault;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  sequence fault_hit;
    fault_now && protect_on;
  endsequence

  sequence tristate_set;
    port_out.dir_clear == ch_pins;
  endsequence

  // An unlocked UPDATE with a valid low-side buffer must copy it across.
  sequence copy_go;
    timer_in.update && !timer_in.update_lock_flag
    && s_q.low_side_buffer_valid;
  endsequence

  // Idle fault path: nothing may keep a direction bit cleared.
  sequence calm;
    !fault_active && !fault_now;
  endsequence

  // Fault path checks. A control write in the fault cycle moves the pin
  // set, so the latency check skips that cycle.
  a_fault_sets_flag: assert property (
    @(posedge mclk) disable iff (!nrst)
    fault_now |=> s_q.fault_flag && timer_error_set)
    else $error("fault did not set flag");
  a_action_latency: assert property (
    @(posedge mclk) disable iff (!nrst)
    fault_hit ##0 (s_q.fault_action_field == 2'h3) ##0 !wr_ctrl
    |=> tristate_set)
    else $error("fault action late");
  a_mask_or: assert property (
    @(posedge mclk) disable iff (!nrst)
    (|(event_lines & s_q.fault_source_mask)) |=> fault_active)
    else $error("masked event ignored");
  a_oven_locked: assert property (
    @(posedge mclk) disable iff (!nrst)
    (s_q.fault_flag || ext_lock) |=> $stable(s_q.output_override_enables))
    else $error("override written while blocked");
  a_ctrl_locked: assert property (
    @(posedge mclk) disable iff (!nrst)
    ext_lock |=> $stable(s_q.chan_en) && $stable(s_q.fault_source_mask))
    else $error("locked register changed");
  a_latched_hold: assert property (
    @(posedge mclk) disable iff (!nrst)
    fault_active && !s_q.restart_mode_bit && s_q.fault_flag && !wr_stat
    |=> fault_active)
    else $error("latched fault left early");
  a_cycle_resume: assert property (
    @(posedge mclk) disable iff (!nrst)
    fault_active && s_q.restart_mode_bit && !fault_now && timer_in.update
    |=> !fault_active)
    else $error("cycle mode did not resume");
  a_copy_lock: assert property (
    @(posedge mclk) disable iff (!nrst)
    timer_in.update_lock_flag && !reg_wr |=> $stable(low_side_delay))
    else $error("copy despite update lock");
  a_flag_clear: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_q.fault_flag && !fault_now && !(wr_stat && reg_wdata[2])
    |=> s_q.fault_flag)
    else $error("fault flag lost");
  a_debug_ignore: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_q.debug_break_ignore_bit && !(|(event_lines & s_q.fault_source_mask))
    |-> !fault_now)
    else $error("ignored break raised a fault");

  // Routing, buffer and release checks. The copy wins over a live write
  // in the same cycle, so the buffer value is what must appear.
  a_buffer_copy: assert property (
    @(posedge mclk) disable iff (!nrst)
    copy_go |=> low_side_delay == $past(s_q.lsbuf))
    else $error("buffer not copied at update");
  a_dir_release: assert property (
    @(posedge mclk) disable iff (!nrst)
    calm |=> port_out.dir_clear == 8'h00)
    else $error("direction still cleared");
  a_action_none: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_q.fault_action_field == 2'h0 |=> port_out.dir_clear == 8'h00)
    else $error("disabled action cleared direction");
  a_pattern_off: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_q.pattern_mode_bit |-> channel_dead_time_enables == 4'h0)
    else $error("dead time active in pattern mode");
  a_common_wave: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_q.common_channel_bit
    |=> dead_time_wave == {4{$past(timer_in.wave[0])}})
    else $error("common channel not distributed");
  a_pattern_enables: assert property (
    @(posedge mclk) disable iff (!nrst)
    s_q.pattern_mode_bit |=> port_out.override_en == $past(s_q.lsd))
    else $error("pattern enables not from low register");
endmodule

// ===== sim/wfpx_timer_model.sv
// Purpose: Timer model that feeds channel waveforms and UPDATE pulses.
// Assumes: Shares the peripheral clock with the extension.
// Notes:   The bench picks the update period and the lock request.
`timescale 1ns/1ps
module wfpx_timer_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] upd_period,
  input wire logic lock_req,
  output wfpx_pkg::wfpx_timer_t timer_in
);
  logic [7:0] cnt_q;

  // The wrap of the counter is the UPDATE pulse, so pulses never come
  // closer than the chosen period. Waves change on most cycles.
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      timer_in <= '0;
    end else begin
      cnt_q <= (cnt_q >= upd_period) ? 8'h00 : cnt_q + 8'h01;
      timer_in.update <= (cnt_q == upd_period);
      timer_in.wave <= cnt_q[4:1] ^ cnt_q[3:0];
      timer_in.update_lock_flag <= lock_req;
    end
  end
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the waveform fault and pattern logic.
// Assumes: Checks are taken at the falling edge, inputs move at rising.
// Notes:   Random values come from a fixed seed.
`timescale 1ns/1ps
module testbench;
  logic mclk, nrst, reg_wr, reg_rd, ext_lock, dbg, lock_req, terr, fact;
  logic [3:0] reg_addr, ctl, cde, dtw, pw;
  logic [7:0] reg_wdata, reg_rdata, ev, lsd, hsd, r, lo, hi, upd_period;
  wfpx_pkg::wfpx_timer_t tin;
  wfpx_pkg::wfpx_port_t pout;
  int seed, n_fail, checks_done, i;

  wfpx_timer_model i_wfpx_timer_model (.mclk(mclk), .nrst(nrst),
    .upd_period(upd_period), .lock_req(lock_req), .timer_in(tin));
  wfpx_top i_wfpx_top (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_lock(ext_lock), .event_lines(ev),
    .debug_halt_request(dbg), .timer_in(tin),
    .channel_dead_time_enables(cde), .dead_time_wave(dtw),
    .low_side_delay(lsd), .high_side_delay(hsd), .port_out(pout),
    .timer_error_set(terr), .fault_active(fact));

  // Free running clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Each channel enable bit owns a pin pair.
  function automatic logic [7:0] pins(input logic [3:0] en);
    for (int k = 0; k < 4; k++) pins[2*k +: 2] = {2{en[k]}};
  endfunction

  // Pattern pins carry channel A where enabled, else the stored value.
  function automatic logic [7:0] pat(input logic [7:0] l, h, input logic a);
    return (l & {8{a}}) | (~l & h);
  endfunction

  task automatic chk(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata, exp);
    @(posedge mclk);
  endtask

  // Let the design sample the inputs, then settle before checking.
  task automatic look();
    @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Waits for an UPDATE pulse; a missing pulse must not hang the run.
  task automatic wait_upd();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (tin.update !== 1'b1 && n < 64);
    if (n == 64) begin
      n_fail++;
      complete_run();
    end
    look();
  endtask

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    {seed, n_fail, checks_done} = {32'd29, 32'd0, 32'd0};
    {nrst, reg_wr, reg_rd, ext_lock, dbg, lock_req} = 6'h00;
    {reg_addr, reg_wdata, ev, upd_period} = {4'h0, 8'h00, 8'h00, 8'h07};
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 5; i++) rd(4'(i), 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h3F);
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h17);
    r = 8'($random(seed));
    wr(4'h2, r);
    rd(4'h2, r);
    ext_lock <= 1'b1;
    wr(4'h0, 8'h00);
    wr(4'h2, ~r);
    wr(4'hC, 8'h5A);
    rd(4'h0, 8'h3F);
    rd(4'h2, r);
    rd(4'hC, 8'h00);
    ext_lock <= 1'b0;
    $display("Register access test done");
    wr(4'hC, 8'hFF);
    for (i = 0; i < 4; i++) begin
      ctl = 4'($random(seed));
      wr(4'h0, {3'h0, i[0], ctl});
      repeat (2) @(negedge mclk);
      pw = tin.wave;
      @(negedge mclk);
      chk({4'h0, dtw}, {4'h0, i[0] ? {4{pw[0]}} : pw});
      chk({4'h0, cde}, {4'h0, ctl});
      chk(pout.override_en, pins(ctl));
      @(posedge mclk);
    end
    {lo, hi} = 16'($random(seed));
    wr(4'h8, lo);
    wr(4'h9, hi);
    wr(4'h0, 8'h2F);
    repeat (2) @(negedge mclk);
    for (i = 0; i < 6; i++) begin
      pw = tin.wave;
      @(negedge mclk);
      chk(pout.override_val, pat(lo, hi, pw[0]));
    end
    chk(pout.override_en, lo);
    chk({4'h0, cde}, 8'h00);
    @(posedge mclk);
    $display("Waveform and pattern test done");
    lock_req <= 1'b1;
    repeat (2) @(posedge mclk);
    r = 8'($random(seed));
    wr(4'hA, r);
    rd(4'h4, 8'h01);
    wait_upd();
    chk(lsd, lo);
    @(posedge mclk);
    lock_req <= 1'b0;
    wait_upd();
    chk(lsd, r);
    @(posedge mclk);
    wr(4'h7, ~r);
    wait_upd();
    chk(hsd, ~r);
    @(posedge mclk);
    rd(4'h4, 8'h00);
    $display("Buffer test done");
    ctl = 4'($random(seed));
    wr(4'h0, {4'h0, ctl});
    wr(4'h3, 8'h07);
    for (i = 0; i < 8; i++) begin
      wr(4'h2, 8'h01 << i);
      ev <= ~(8'h01 << i);
      look();
      chk({7'h0, fact}, 8'h00);
      @(posedge mclk);
      ev <= 8'h01 << i;
      look();
      chk({7'h0, fact}, 8'h01);
      chk({7'h0, terr}, 8'h01);
      chk(pout.dir_clear, pins(ctl));
      @(posedge mclk);
      ev <= 8'h00;
      wait_upd();
      chk({7'h0, fact}, 8'h00);
      @(negedge mclk);
      chk(pout.dir_clear, 8'h00);
      @(posedge mclk);
      rd(4'h4, 8'h04);
      wr(4'h4, 8'h04);
    end
    wr(4'h3, 8'h03);
    ev <= 8'h80;
    @(posedge mclk);
    ev <= 8'h00;
    wr(4'hC, 8'h00);
    wait_upd();
    chk({7'h0, fact}, 8'h01);
    @(posedge mclk);
    rd(4'hC, 8'hFF);
    wr(4'h4, 8'h04);
    wait_upd();
    chk({7'h0, fact}, 8'h00);
    @(posedge mclk);
    $display("Fault test done");
    wr(4'h3, 8'h07);
    dbg <= 1'b1;
    look();
    chk({7'h0, fact}, 8'h01);
    @(posedge mclk);
    dbg <= 1'b0;
    wait_upd();
    chk({7'h0, fact}, 8'h00);
    @(posedge mclk);
    wr(4'h4, 8'h04);
    wr(4'h3, 8'h17);
    dbg <= 1'b1;
    look();
    chk({7'h0, fact}, 8'h00);
    @(posedge mclk);
    wr(4'h3, 8'h04);
    look();
    chk({7'h0, fact}, 8'h00);
    $display("Debug break test done");
    complete_run();
  end
endmodule
